/* vic_map.vh */
// Register offsets, field positions and reset values of the interrupt status and command block.
// Assumes byte addressing on a 32-bit APB slave, one aligned word per register.
`ifndef VIC_MAP_VH
`define VIC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VIC_OFS_NORMAL_VECTOR 12'h100
`define VIC_OFS_FAST_VECTOR 12'h104
`define VIC_OFS_CURRENT_ID 12'h108
`define VIC_OFS_PENDING 12'h10c
`define VIC_OFS_MASK 12'h110
`define VIC_OFS_CORE_LINE 12'h114
`define VIC_OFS_ENABLE_CMD 12'h120
`define VIC_OFS_DISABLE_CMD 12'h124
`define VIC_OFS_CLEAR_CMD 12'h128
`define VIC_OFS_SET_CMD 12'h12c
`define VIC_OFS_END_SERVICE 12'h130
`define VIC_OFS_SPURIOUS 12'h134
`define VIC_OFS_DEBUG 12'h138
`define VIC_OFS_FAST_FORCE_EN 12'h140
`define VIC_OFS_EVT_STATUS 12'h150
`define VIC_OFS_EVT_MASK 12'h154

// ****************************************************************
// Field positions
// ****************************************************************
`define VIC_BIT_FAST_SOURCE 0
`define VIC_BIT_SYSTEM_SOURCE 1
`define VIC_BIT_FAST_LINE 0
`define VIC_BIT_NORMAL_LINE 1
`define VIC_BIT_PROTECTION 0
`define VIC_BIT_GLOBAL_MASK 1
`define VIC_EVT_SPURIOUS 0
`define VIC_EVT_END_SERVICE 1
`define VIC_EVT_NORMAL_RAISE 2
`define VIC_EVT_FAST_RAISE 3
`define VIC_EVT_WIDTH 4

// ****************************************************************
// Reset values
// ****************************************************************
`define VIC_RST_WORD 32'h0000_0000
`define VIC_RST_EVT 4'h0

`endif

/* vic_sync3.v */
// Three-stage input synchroniser with a two-stage agreement filter.
// Assumes asynchronous inputs; output moves only when stages two and three agree.
module vic_sync3 #(
	parameter W = 32
) (
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stage1 <= {W{1'b0}};
		stage2 <= {W{1'b0}};
		stage3 <= {W{1'b0}};
		sync_out <= {W{1'b0}};
	end else begin
		stage1 <= async_in;
		stage2 <= stage1;
		stage3 <= stage2;
		// Hold per bit while stages two and three disagree
		sync_out <= (stage3 & ~(stage2 ^ stage3)) | (sync_out & (stage2 ^ stage3));
	end
end

endmodule // vic_sync3

/* vic_regs.v */
// Status and command registers of a 32-source vectored interrupt controller with APB access.
// Assumes one clock pclk, asynchronous active-low presetn, sources arriving from pins.
//
// Contract
// R01: Fast bit 0, system bit 1, peripherals 2-31.
// R02: Pending register reads pending sources as one.
// R03: Mask register reads enabled sources as one.
// R04: Core status shows fast and normal lines.
// R05: Enable command sets mask bits written one.
// R06: Disable command clears mask bits written one.
// R07: Clear command clears pending bits written one.
// R08: Set command makes sources written one pending.
// R09: Any end-of-service write completes current service.
// R10: Spurious vector returned on spurious vector reads.
// R11: Debug bit 0 holds protection mode, resets zero.
// R12: Debug bit 1 holds both lines inactive.
// R13: Fast forcing write-only, bit 0 unused.
// R14: Fast forcing write one enables, zero ignored.
// R15: No current interrupt: normal vector reads spurious.
// R16: Multi-bit commands apply together; reserved bits zero.
// R17: Software command beats same-cycle hardware event; event status write-one clears lose to same-cycle new events.
`include "vic_map.vh"

module vic_regs #(
	parameter NSRC = 32
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NSRC-1:0] source_in,
	output reg normal_request_line_n,
	output reg fast_request_line_n,
	output wire irq_out
);

// ****************************************************************
// State
// ****************************************************************
reg [NSRC-1:0] pending_status;
reg [NSRC-1:0] mask_status;
reg [NSRC-1:0] fast_force;
reg [31:0] spurious_vector;
reg protection_enable;
reg global_line_mask;
reg in_service;
reg [4:0] current_id;
reg [NSRC-1:0] source_prev;
reg bad_addr;
reg [`VIC_EVT_WIDTH-1:0] evt_status;
reg [`VIC_EVT_WIDTH-1:0] evt_mask;
reg normal_prev;
reg fast_prev;
// Captured at setup so the access edge acknowledges what the read returned
reg [4:0] read_id;
reg read_hit;
reg read_fast;

wire [NSRC-1:0] source_sync;
wire [NSRC-1:0] source_rise;
wire [NSRC-1:0] active;
wire [NSRC-1:0] normal_active;
wire fast_active;
wire normal_want;
wire fast_want;
wire setup_phase;
wire access_phase;
wire wr_access;
wire rd_access;
wire cmd_enable;
wire cmd_disable;
wire cmd_clear;
wire cmd_set;
reg [4:0] next_id;
reg next_found;
reg [31:0] next_rdata;
reg next_bad;
integer i;

// ****************************************************************
// Source synchronisation and edge detection
// ****************************************************************
vic_sync3 #(
	.W(NSRC)
) u_sync (
	.pclk(pclk),
	.presetn(presetn),
	.async_in(source_in),
	.sync_out(source_sync)
);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		source_prev <= {NSRC{1'b0}};
	end else begin
		source_prev <= source_sync;
	end
end

assign source_rise = source_sync & ~source_prev;

// ****************************************************************
// Request line logic
// ****************************************************************
assign active = pending_status & mask_status;
// Forced sources go to the fast line; bit 0 always does
assign fast_active = active[`VIC_BIT_FAST_SOURCE] | (|(active & fast_force)); // R01
assign normal_active = active & ~fast_force & {{(NSRC-1){1'b1}}, 1'b0}; // R01

// Lowest-numbered normal source becomes the current candidate
always @* begin
	next_id = 5'h00;
	next_found = 1'b0;
	for (i = NSRC - 1; i >= 1; i = i - 1) begin
		if (normal_active[i]) begin
			next_id = i[4:0];
			next_found = 1'b1;
		end
	end
end

assign normal_want = next_found & ~in_service;
assign fast_want = fast_active;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		normal_request_line_n <= 1'b1;
		fast_request_line_n <= 1'b1;
		normal_prev <= 1'b0;
		fast_prev <= 1'b0;
	end else begin
		normal_request_line_n <= ~(normal_want & ~global_line_mask); // R12
		fast_request_line_n <= ~(fast_want & ~global_line_mask); // R12
		normal_prev <= ~normal_request_line_n;
		fast_prev <= ~fast_request_line_n;
	end
end

// ****************************************************************
// APB decode
// ****************************************************************
assign setup_phase = psel & ~penable;
assign access_phase = psel & penable;
assign wr_access = access_phase & pwrite;
assign rd_access = access_phase & ~pwrite;
assign pready = 1'b1;
assign pslverr = access_phase & bad_addr;

// Read data is formed in setup and registered for the access phase
always @* begin
	next_rdata = 32'h0000_0000;
	next_bad = 1'b0;
	case (paddr)
		`VIC_OFS_NORMAL_VECTOR: begin
			if (next_found & ~in_service) begin
				next_rdata = {27'h0, next_id};
			end else begin
				next_rdata = spurious_vector; // R15 R10
			end
		end
		`VIC_OFS_FAST_VECTOR: begin
			if (fast_active) begin
				next_rdata = 32'h0000_0000;
			end else begin
				next_rdata = spurious_vector; // R10
			end
		end
		`VIC_OFS_CURRENT_ID: begin
			next_rdata = {27'h0, current_id};
		end
		`VIC_OFS_PENDING: begin
			next_rdata = pending_status; // R02
		end
		`VIC_OFS_MASK: begin
			next_rdata = mask_status; // R03
		end
		`VIC_OFS_CORE_LINE: begin
			next_rdata[`VIC_BIT_FAST_LINE] = ~fast_request_line_n; // R04
			next_rdata[`VIC_BIT_NORMAL_LINE] = ~normal_request_line_n; // R04
		end
		`VIC_OFS_ENABLE_CMD, `VIC_OFS_DISABLE_CMD, `VIC_OFS_CLEAR_CMD,
		`VIC_OFS_SET_CMD, `VIC_OFS_END_SERVICE, `VIC_OFS_FAST_FORCE_EN: begin
			next_rdata = 32'h0000_0000; // R13
		end
		`VIC_OFS_SPURIOUS: begin
			next_rdata = spurious_vector;
		end
		`VIC_OFS_DEBUG: begin
			next_rdata[`VIC_BIT_PROTECTION] = protection_enable; // R16
			next_rdata[`VIC_BIT_GLOBAL_MASK] = global_line_mask;
		end
		`VIC_OFS_EVT_STATUS: begin
			next_rdata = {{(32-`VIC_EVT_WIDTH){1'b0}}, evt_status};
		end
		`VIC_OFS_EVT_MASK: begin
			next_rdata = {{(32-`VIC_EVT_WIDTH){1'b0}}, evt_mask};
		end
		default: begin
			next_bad = 1'b1;
		end
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= `VIC_RST_WORD;
		bad_addr <= 1'b0;
		read_id <= 5'h00;
		read_hit <= 1'b0;
		read_fast <= 1'b0;
	end else if (setup_phase) begin
		prdata <= pwrite ? 32'h0000_0000 : next_rdata;
		bad_addr <= next_bad;
		// A source edge between setup and access must not change the acknowledged source
		read_id <= next_id;
		read_hit <= next_found & ~in_service;
		read_fast <= fast_active;
	end
end

// ****************************************************************
// Mask and pending state
// ****************************************************************
// One write strobe per command register
assign cmd_enable = wr_access && paddr == `VIC_OFS_ENABLE_CMD;
assign cmd_disable = wr_access && paddr == `VIC_OFS_DISABLE_CMD;
assign cmd_clear = wr_access && paddr == `VIC_OFS_CLEAR_CMD;
assign cmd_set = wr_access && paddr == `VIC_OFS_SET_CMD;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mask_status <= `VIC_RST_WORD;
	end else if (cmd_enable) begin
		mask_status <= mask_status | pwdata[NSRC-1:0]; // R05 R16
	end else if (cmd_disable) begin
		mask_status <= mask_status & ~pwdata[NSRC-1:0]; // R06 R16
	end
end

// Reading the normal vector acknowledges the source captured at its setup edge; a fast vector read clears only bit 0
wire normal_ack;
wire fast_ack;
wire [NSRC-1:0] ack_clear;
assign normal_ack = rd_access && paddr == `VIC_OFS_NORMAL_VECTOR && read_hit;
assign fast_ack = rd_access && paddr == `VIC_OFS_FAST_VECTOR && read_fast;
assign ack_clear = ({{(NSRC-1){1'b0}}, normal_ack} << read_id) |
	({{(NSRC-1){1'b0}}, fast_ack} & {{(NSRC-1){1'b0}}, active[0]});

// A software clear beats a source edge of the same cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pending_status <= `VIC_RST_WORD;
	end else if (cmd_clear) begin
		pending_status <= (pending_status | source_rise) & ~pwdata[NSRC-1:0]; // R07 R17 R16
	end else if (cmd_set) begin
		pending_status <= pending_status | source_rise | pwdata[NSRC-1:0]; // R08 R16
	end else begin
		pending_status <= (pending_status & ~ack_clear) | source_rise;
	end
end

// ****************************************************************
// Service tracking
// ****************************************************************
wire eos_write;
assign eos_write = wr_access && paddr == `VIC_OFS_END_SERVICE;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		in_service <= 1'b0;
		current_id <= 5'h00;
	end else if (eos_write) begin
		in_service <= 1'b0; // R09
	end else if (normal_ack) begin
		in_service <= 1'b1;
		current_id <= read_id;
	end
end

// ****************************************************************
// Configuration registers
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		spurious_vector <= `VIC_RST_WORD;
		protection_enable <= 1'b0;
		global_line_mask <= 1'b0;
		fast_force <= {NSRC{1'b0}};
		evt_mask <= `VIC_RST_EVT;
	end else if (wr_access) begin
		if (paddr == `VIC_OFS_SPURIOUS) begin
			spurious_vector <= pwdata; // R10
		end
		if (paddr == `VIC_OFS_DEBUG) begin
			protection_enable <= pwdata[`VIC_BIT_PROTECTION]; // R11
			global_line_mask <= pwdata[`VIC_BIT_GLOBAL_MASK]; // R12
		end
		if (paddr == `VIC_OFS_FAST_FORCE_EN) begin
			fast_force <= fast_force | (pwdata & {{(NSRC-1){1'b1}}, 1'b0}); // R13 R14
		end
		if (paddr == `VIC_OFS_EVT_MASK) begin
			evt_mask <= pwdata[`VIC_EVT_WIDTH-1:0];
		end
	end
end

// ****************************************************************
// Event status and interrupt output
// ****************************************************************
reg [`VIC_EVT_WIDTH-1:0] evt_set;
reg [`VIC_EVT_WIDTH-1:0] evt_clr;

always @* begin
	evt_set = `VIC_RST_EVT;
	evt_set[`VIC_EVT_SPURIOUS] = rd_access && paddr == `VIC_OFS_NORMAL_VECTOR &&
		!read_hit;
	evt_set[`VIC_EVT_END_SERVICE] = eos_write;
	evt_set[`VIC_EVT_NORMAL_RAISE] = ~normal_request_line_n & ~normal_prev;
	evt_set[`VIC_EVT_FAST_RAISE] = ~fast_request_line_n & ~fast_prev;
	evt_clr = `VIC_RST_EVT;
	if (wr_access && paddr == `VIC_OFS_EVT_STATUS) begin
		evt_clr = pwdata[`VIC_EVT_WIDTH-1:0];
	end
end

// New events win over a same-cycle write-one clear
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		evt_status <= `VIC_RST_EVT;
	end else begin
		evt_status <= (evt_status & ~evt_clr) | evt_set;
	end
end

assign irq_out = |(evt_status & evt_mask);

endmodule // vic_regs

/* vic_regs_monitor.sv */
// Port-level checks of the interrupt status and command registers.
// Assumes zero-wait APB and registered request lines.
module vic_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire normal_request_line_n,
	input wire fast_request_line_n
);
	timeunit 1ns;
	timeprecision 1ps;
	wire srd = psel && !penable && !pwrite;
	wire awr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_no_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
	chk_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	chk_hole_err: assert property (psel && penable && paddr == 12'h11c |-> pslverr)
		else $error("no error on hole");
	chk_write_rdata: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
		else $error("read data on write");
	chk_wo_zero: assert property (srd && (paddr[11:4] == 8'h12 || paddr == 12'h140)
		|=> prdata == 32'h0) else $error("write-only reads nonzero");
	chk_line_status: assert property (srd && paddr == 12'h114 |=> prdata ==
		{30'h0, ~$past(normal_request_line_n), ~$past(fast_request_line_n)})
		else $error("line status wrong");
	chk_gmask_lines: assert property (awr && paddr == 12'h138 && pwdata[1] |->
		##2 normal_request_line_n && fast_request_line_n) else $error("lines not masked");
	chk_mask_update: assert property (awr && paddr == 12'h120 ##1 srd && paddr == 12'h110
		|=> (prdata & $past(pwdata, 2)) == $past(pwdata, 2)) else $error("enable lost");
endmodule // vic_monitor
bind vic_regs vic_monitor vic_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .normal_request_line_n(normal_request_line_n),
	.fast_request_line_n(fast_request_line_n));

/* vic_core_model.sv */
// Processor core side: samples the two active-low request lines.
// Assumes lines are registered on pclk.
module vic_core_model (
	input wire pclk,
	input wire presetn,
	input wire normal_request_line_n,
	input wire fast_request_line_n,
	output logic n_tk,
	output logic f_tk
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_tk <= 1'b0;
			f_tk <= 1'b0;
		end else begin
			n_tk <= ~normal_request_line_n;
			f_tk <= ~fast_request_line_n;
		end
	end
endmodule // vic_core_model

/* vectored_irq_status_command_regs_test.sv */
// Self-checking bench of the interrupt register block with a core model.
// Assumes zero-wait APB slave and 200 MHz pclk.
module vectored_irq_status_command_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, source_in = 0, rd, p, e, d, seed = 32'h0000_73a8;
	logic [11:0] ra [5] = '{12'h10c, 12'h110, 12'h114, 12'h134, 12'h138};
	wire [31:0] prdata;
	wire pready, pslverr, nl_n, fl_n, irq_out, n_tk, f_tk;
	int num_errors = 0, n_tests = 0;
	always #2.5 pclk = ~pclk;
	vic_regs #(.NSRC(32)) vic_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_in(source_in), .irq_out(irq_out),
		.normal_request_line_n(nl_n), .fast_request_line_n(fl_n));
	vic_core_model vic_core_model_inst (.pclk(pclk), .presetn(presetn),
		.normal_request_line_n(nl_n), .fast_request_line_n(fl_n), .n_tk(n_tk), .f_tk(f_tk));
	// ********
	// Helpers
	// ********
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected core line status: bit 0 fast source, bit 1 any other active source
	function automatic logic [31:0] lines_exp(input logic [31:0] act);
		return {30'h0, |act[31:1], act[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] x);
		n_tests++;
		if (seen !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, x, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input bit chain = 0);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		penable <= 1'b0;
		if (!chain) begin
			psel <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic w(input logic [11:0] a, input logic [31:0] x);
		apb(1'b1, a, x);
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, rd, x);
	endtask
	task automatic end_sim;
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ********
	// Tests
	// ********
	initial begin
		#50000;
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ra[i]) rc("reset", ra[i], 32'h0);
		repeat (3) begin
			seed = lfsr(seed);
			e = seed;
			seed = lfsr(seed);
			d = seed;
			w(12'h134, e);
			rc("spu", 12'h134, e);
			w(12'h138, d & 32'hffff_fffd);
			rc("dbg", 12'h138, d & 32'h1);
			w(12'h124, 32'hffff_ffff);
			apb(1'b1, 12'h120, e, 1);
			apb(1'b0, 12'h110, 32'h0);
			chk("mask", rd, e);
			w(12'h124, d);
			rc("mask", 12'h110, e & ~d);
			w(12'h128, 32'hffff_ffff);
			w(12'h12c, e);
			rc("pend", 12'h10c, e);
			w(12'h128, d);
			p = e & ~d;
			rc("pend", 12'h10c, p);
			rc("cisr", 12'h114, lines_exp(p));
			chk("core", {n_tk, f_tk}, lines_exp(p));
		end
		w(12'h120, 32'hffff_ffff);
		w(12'h12c, 32'hffff_ffff);
		w(12'h138, 32'h2);
		rc("global_line_mask", 12'h114, 32'h0);
		chk("core", {n_tk, f_tk}, 2'b00);
		w(12'h138, 32'h0);
		w(12'h128, 32'hffff_ffff);
		rc("ivr", 12'h100, e);
		rc("fvr", 12'h104, e);
		w(12'h150, 32'hf);
		w(12'h154, 32'h2);
		rc("emask", 12'h154, 32'h2);
		chk("irq", irq_out, 1'b0);
		w(12'h130, lfsr(seed));
		chk("irq", irq_out, 1'b1);
		w(12'h150, 32'h2);
		chk("irq", irq_out, 1'b0);
		rc("ffer", 12'h140, 32'h0);
		w(12'h140, 32'h8);
		w(12'h12c, 32'h8);
		rc("force", 12'h114, 32'h1);
		w(12'h128, 32'hffff_ffff);
		source_in <= 32'h20;
		repeat (10) @(posedge pclk);
		rc("src", 12'h10c, 32'h20);
		apb(1'b0, 12'h11c, 32'h0);
		chk("hole", er, 1'b1);
		// Service one normal source, block the line while in service, then end it
		rc("ivr", 12'h100, 32'h5);
		rc("isr", 12'h108, 32'h5);
		rc("pend", 12'h10c, 32'h0);
		w(12'h12c, 32'h4);
		rc("busy", 12'h114, 32'h0);
		w(12'h130, e);
		rc("eos", 12'h114, 32'h2);
		chk("irq", irq_out, 1'b1);
		w(12'h12c, 32'h1);
		rc("fvr", 12'h104, 32'h0);
		rc("pend", 12'h10c, 32'h4);
		end_sim;
	end
endmodule // vectored_irq_status_command_regs_test
